// *** rtl/ufi_cfg.svh ***
// Offsets, bit positions and timing counts shared by both link ends
`ifndef UFI_CFG_SVH
`define UFI_CFG_SVH
`define UFI_REG_PEND     7'h00
`define UFI_REG_MASK     7'h01
`define UFI_REG_FADDR    7'h02
`define UFI_B_EP0TX      0
`define UFI_B_EP0RX      1
`define UFI_B_EP1_TRANSMIT_FLAG      2
`define UFI_B_FUNCTION_RESET_FLAG       3
`define UFI_B_FUNCTION_SUSPEND_FLAG      4
`define UFI_NFLAG        5
`define UFI_RST_BYTE     8'h00
`define UFI_RST_ADDR     7'h00
`define UFI_RST_MASK     5'h00
`define UFI_HDR_BITS     5'd8
`define UFI_FRAME_BITS   5'd16
`define UFI_LAST_BIT     5'd15
`define UFI_CLK_NS       8
`define UFI_SCL_HALF_NS  64
`define UFI_SCL_HALF_CYC 4'((`UFI_SCL_HALF_NS + `UFI_CLK_NS - 1) / `UFI_CLK_NS)
`define UFI_AXI_CMD      4'h0
`define UFI_AXI_STAT     4'h4
`define UFI_AXI_RDATA    4'h8
`define UFI_RESP_OKAY    2'b00
`define UFI_RESP_SLVERR  2'b10
`endif

// *** rtl/ufi_pkg.sv ***
// Types used by the controller link end
package ufi_pkg;
  typedef enum logic [2:0] {
    UFI_IDLE  = 3'h0,
    UFI_START = 3'h1,
    UFI_LOW   = 3'h3,
    UFI_RISE  = 3'h2,
    UFI_HIGH  = 3'h6,
    UFI_STP0  = 3'h7,
    UFI_STP1  = 3'h5,
    UFI_STP2  = 3'h4
  } ufi_mst_state_type;
  typedef logic [7:0] ufi_byte_type;
endpackage

// *** rtl/ufi_link_if.sv ***
// Two-wire register link plus interrupt pin between controller and function
`timescale 1ns/10ps
interface ufi_link_if;
  logic scl;
  logic sda_mcu_drv;
  logic sda_mcu_oe_n;
  logic sda_dev_drv;
  logic sda_dev_oe_n;
  logic sda;
  logic irq;
  // Released line floats high
  assign sda = !sda_dev_oe_n ? sda_dev_drv : (!sda_mcu_oe_n ? sda_mcu_drv : 1'b1);
  modport dev (input scl, input sda, output sda_dev_drv, output sda_dev_oe_n, output irq);
  modport mcu (output scl, output sda_mcu_drv, output sda_mcu_oe_n, input sda, input irq);
endinterface

// *** rtl/ufi_dev.sv ***
// Embedded function interrupt, mask and address registers behind the two-wire link
`timescale 1ns/10ps
`include "ufi_cfg.svh"
// Function
// - IRQ high while any enabled flag pending
// - Disabled flags still set, IRQ stays low
// - Mask bits per flag, read/write, reset clear
// - Suspend flag set on suspend detect
// - Suspend entered only after suspend flag cleared
// - Write one clears suspend/reset flags
// - Reset flag set on host port reset
// - Function reset only after reset flag cleared
// - Function reset spares enables, reset flag, masks
// - EP1 transmit flag follows its causes
// - EP0 receive flag follows its causes
// - EP0 transmit flag follows its causes
// - Endpoint flags read-only, clear with causes
// - Set Address loads address field automatically
// - Enabled bit set by port enable, read-only
// - Firmware writes new address over link
// - Firmware writes zero to reserved bits
// - Single-byte register reads and writes over link
module ufi_dev (
  input  wire logic       aclk,              // device clock
  input  wire logic       aresetn,           // synchronous reset, active low
  ufi_link_if.dev         link,              // two-wire link and interrupt pin
  input  wire logic       suspend_detect,    // hub suspend logic, level
  input  wire logic       port_reset_detect, // host port reset, level
  input  wire logic [2:0] ep1_tx_cause,      // ack, overrun, underrun
  input  wire logic [2:0] ep0_rx_cause,      // ack, overrun, underrun
  input  wire logic [2:0] ep0_tx_cause,      // ack, overrun, underrun
  input  wire logic       set_address_stb,   // Set Address request seen
  input  wire logic [6:0] set_address_val,   // address from that request
  input  wire logic       port_enable_stb,   // set port feature enable seen
  output logic            low_power_q,       // suspend state, clocks may stop
  output logic            function_reset_q   // one-cycle function reset
);
  // Pin synchronisers, index 1 is clock line, 0 is data line
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_f_q;
  logic [1:0] pin_p_q;
  logic       active_q;
  logic       rd_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic [6:0] addr_q;
  logic [7:0] tx_q;
  logic       drv_q;
  logic       oe_n_q;
  logic       irq_q;
  logic       function_suspend_flag_q;
  logic       function_reset_flag_q;
  logic [2:0] ep_q;
  logic [4:0] mask_q;
  logic [6:0] fa_q;
  logic       fen_q;
  logic       susp_in_q;
  logic       rst_in_q;
  logic       susp_req_q;
  logic       rst_req_q;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_f_q[gi] <= 1'b1;
        end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
          pin_f_q[gi] <= pin_s3_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
      pin_s3_q <= 2'h3;
      pin_p_q  <= 2'h3;
    end else begin
      pin_s1_q <= {link.scl, link.sda};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_p_q  <= pin_f_q;
    end
  end

  // Link framing: start, 8 header bits, 8 data bits, stop
  wire        scl_rise   = pin_f_q[1] & ~pin_p_q[1];
  wire        scl_fall   = ~pin_f_q[1] & pin_p_q[1];
  wire        hi_hold    = pin_f_q[1] & pin_p_q[1];
  wire        start_cond = hi_hold & ~pin_f_q[0] & pin_p_q[0];
  wire        stop_cond  = hi_hold & pin_f_q[0] & ~pin_p_q[0];
  wire [15:0] sh_nx      = {sh_q[14:0], pin_f_q[0]};
  wire        bit_take   = scl_rise & active_q & (cnt_q < `UFI_FRAME_BITS);
  wire        hdr_done   = bit_take & (cnt_q == `UFI_HDR_BITS - 5'd1);
  wire        frame_done = bit_take & (cnt_q == `UFI_LAST_BIT);
  wire        tx_slot    = active_q & rd_q & (cnt_q >= `UFI_HDR_BITS)
                           & (cnt_q < `UFI_FRAME_BITS);
  wire        wr_stb     = frame_done & ~rd_q;
  wire [7:0]  wr_data    = sh_nx[7:0];
  wire [6:0]  hdr_addr   = sh_nx[6:0];

  // Register decode
  wire wr_pend  = wr_stb & (addr_q == `UFI_REG_PEND);
  wire wr_mask  = wr_stb & (addr_q == `UFI_REG_MASK);
  wire wr_faddr = wr_stb & (addr_q == `UFI_REG_FADDR);
  wire [4:0] pend = {function_suspend_flag_q, function_reset_flag_q, ep_q};
  wire [7:0] rd_mux = (hdr_addr == `UFI_REG_PEND)  ? {3'h0, pend} :
                      (hdr_addr == `UFI_REG_MASK)  ? {3'h0, mask_q} :
                      (hdr_addr == `UFI_REG_FADDR) ? {fen_q, fa_q} :
                      `UFI_RST_BYTE;

  // Hub events counted on their rising edge
  wire susp_set  = suspend_detect & ~susp_in_q;
  wire rst_set   = port_reset_detect & ~rst_in_q;
  wire susp_w1c  = wr_pend & wr_data[`UFI_B_FUNCTION_SUSPEND_FLAG];
  wire rst_w1c   = wr_pend & wr_data[`UFI_B_FUNCTION_RESET_FLAG];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 5'h00;
      sh_q     <= 16'h0000;
      addr_q   <= `UFI_RST_ADDR;
      tx_q     <= `UFI_RST_BYTE;
      drv_q    <= 1'b1;
      oe_n_q   <= 1'b1;
    end else if (start_cond) begin
      active_q <= 1'b1;
      rd_q     <= 1'b0;
      cnt_q    <= 5'h00;
      oe_n_q   <= 1'b1;
    end else if (stop_cond) begin
      active_q <= 1'b0;
      oe_n_q   <= 1'b1;
    end else begin
      if (bit_take) begin
        sh_q  <= sh_nx;
        cnt_q <= cnt_q + 5'd1;
      end
      if (hdr_done) begin
        rd_q   <= sh_nx[7];
        addr_q <= hdr_addr;
        tx_q   <= rd_mux;
      end
      if (scl_fall && tx_slot) begin
        drv_q  <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
        oe_n_q <= 1'b0;
      end else if (scl_fall) begin
        oe_n_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp_in_q <= 1'b0;
      rst_in_q  <= 1'b0;
      function_suspend_flag_q   <= 1'b0;
      function_reset_flag_q    <= 1'b0;
      ep_q      <= 3'h0;
      mask_q    <= `UFI_RST_MASK;
      irq_q     <= 1'b0;
    end else begin
      susp_in_q <= suspend_detect;
      rst_in_q  <= port_reset_detect;
      // Set wins over write-one clear and over function reset
      function_suspend_flag_q   <= susp_set | (function_suspend_flag_q & ~susp_w1c & ~function_reset_q);
      function_reset_flag_q    <= rst_set | (function_reset_flag_q & ~rst_w1c);
      ep_q[`UFI_B_EP1_TRANSMIT_FLAG] <= |ep1_tx_cause;
      ep_q[`UFI_B_EP0RX] <= |ep0_rx_cause;
      ep_q[`UFI_B_EP0TX] <= |ep0_tx_cause;
      if (wr_mask) begin
        mask_q <= wr_data[4:0];
      end
      // Mask bit set enables its flag onto the pin
      irq_q <= |(pend & mask_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fa_q  <= `UFI_RST_ADDR;
      fen_q <= 1'b0;
    end else begin
      if (function_reset_q) begin
        fa_q <= `UFI_RST_ADDR;
      end else if (set_address_stb) begin
        fa_q <= set_address_val;
      end else if (wr_faddr) begin
        fa_q <= wr_data[6:0];
      end
      if (port_enable_stb) begin
        fen_q <= 1'b1;
      end
    end
  end

  // Suspend and function reset wait for firmware to clear their flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp_req_q       <= 1'b0;
      rst_req_q        <= 1'b0;
      low_power_q      <= 1'b0;
      function_reset_q <= 1'b0;
    end else begin
      function_reset_q <= 1'b0;
      if (susp_set) begin
        susp_req_q <= 1'b1;
      end else if (susp_req_q && !function_suspend_flag_q && suspend_detect) begin
        susp_req_q  <= 1'b0;
        low_power_q <= 1'b1;
      end else if (!suspend_detect || function_reset_q) begin
        susp_req_q  <= 1'b0;
        low_power_q <= 1'b0;
      end
      if (rst_set) begin
        rst_req_q <= 1'b1;
      end else if (rst_req_q && !function_reset_flag_q) begin
        rst_req_q        <= 1'b0;
        function_reset_q <= 1'b1;
      end
    end
  end

  assign link.sda_dev_drv  = drv_q;
  assign link.sda_dev_oe_n = oe_n_q;
  assign link.irq          = irq_q;
endmodule

// *** rtl/ufi_mcu.sv ***
// Controller end: AXI4-Lite command registers driving the two-wire link
`timescale 1ns/10ps
`include "ufi_cfg.svh"
module ufi_mcu (
  input  wire logic        aclk,          // controller clock
  input  wire logic        aresetn,       // synchronous reset, active low
  ufi_link_if.mcu          link,          // two-wire link and interrupt pin
  input  wire logic [3:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [3:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready   // read data ready
);
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [1:0]  s1_q;
  logic [1:0]  s2_q;
  logic [1:0]  s3_q;
  logic [1:0]  f_q;
  logic [3:0]  div_q;
  ufi_pkg::ufi_mst_state_type state_q;
  logic [4:0]  bit_q;
  logic [15:0] cmd_q;
  logic [15:0] shift_q;
  ufi_pkg::ufi_byte_type rx_q;
  ufi_pkg::ufi_byte_type rdbuf_q;
  logic        busy_q;
  logic        scl_q;
  logic        drv_q;
  logic        oe_n_q;

  wire do_wr    = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire hit_cmd  = awaddr_q == `UFI_AXI_CMD;
  wire wr_hit   = hit_cmd | (awaddr_q == `UFI_AXI_STAT) | (awaddr_q == `UFI_AXI_RDATA);
  wire launch   = do_wr & hit_cmd & (wstrb_q[1:0] == 2'h3) & ~busy_q;
  wire rd_take  = s_axi_arvalid & s_axi_arready;
  wire rd_cmd   = s_axi_araddr == `UFI_AXI_CMD;
  wire rd_stat  = s_axi_araddr == `UFI_AXI_STAT;
  wire rd_data  = s_axi_araddr == `UFI_AXI_RDATA;
  wire [31:0] rd_mux = rd_cmd  ? {16'h0000, cmd_q} :
                       rd_stat ? {30'h0, f_q[1], busy_q} :
                       rd_data ? {24'h000000, rdbuf_q} : 32'h00000000;
  wire tick     = div_q == (`UFI_SCL_HALF_CYC - 4'd1);
  wire reading  = cmd_q[15] & (bit_q >= `UFI_HDR_BITS);

  // AXI4-Lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UFI_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `UFI_RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      // Write ready flags always equal the inverted have flags, updated in the same cycle
      if (do_wr) begin
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? `UFI_RESP_OKAY : `UFI_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_arready <= 1'b0;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= (rd_cmd | rd_stat | rd_data) ? `UFI_RESP_OKAY : `UFI_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Data line and interrupt pin synchronisers, index 1 is interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 2'h1;
      s2_q <= 2'h1;
      s3_q <= 2'h1;
      f_q  <= 2'h1;
    end else begin
      s1_q <= {link.irq, link.sda};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    end
  end

  // Link master, one step per half clock period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q   <= 4'h0;
      state_q <= ufi_pkg::UFI_IDLE;
      bit_q   <= 5'h00;
      cmd_q   <= 16'h0000;
      shift_q <= 16'h0000;
      rx_q    <= `UFI_RST_BYTE;
      rdbuf_q <= `UFI_RST_BYTE;
      busy_q  <= 1'b0;
      scl_q   <= 1'b1;
      drv_q   <= 1'b1;
      oe_n_q  <= 1'b1;
    end else begin
      div_q <= tick ? 4'h0 : div_q + 4'd1;
      if (launch) begin
        busy_q  <= 1'b1;
        cmd_q   <= wdata_q[15:0];
        shift_q <= wdata_q[15:0];
      end
      if (tick) begin
        case (state_q)
          ufi_pkg::UFI_IDLE: begin
            if (busy_q) begin
              drv_q   <= 1'b0;
              oe_n_q  <= 1'b0;
              bit_q   <= 5'h00;
              state_q <= ufi_pkg::UFI_START;
            end
          end
          ufi_pkg::UFI_START: begin
            scl_q   <= 1'b0;
            state_q <= ufi_pkg::UFI_LOW;
          end
          ufi_pkg::UFI_LOW: begin
            drv_q   <= shift_q[15];
            oe_n_q  <= reading;
            state_q <= ufi_pkg::UFI_RISE;
          end
          ufi_pkg::UFI_RISE: begin
            scl_q   <= 1'b1;
            state_q <= ufi_pkg::UFI_HIGH;
          end
          ufi_pkg::UFI_HIGH: begin
            if (reading) begin
              rx_q <= {rx_q[6:0], f_q[0]};
            end
            scl_q   <= 1'b0;
            shift_q <= {shift_q[14:0], 1'b0};
            bit_q   <= bit_q + 5'd1;
            state_q <= (bit_q == `UFI_LAST_BIT) ? ufi_pkg::UFI_STP0 : ufi_pkg::UFI_LOW;
          end
          ufi_pkg::UFI_STP0: begin
            drv_q   <= 1'b0;
            oe_n_q  <= 1'b0;
            state_q <= ufi_pkg::UFI_STP1;
          end
          ufi_pkg::UFI_STP1: begin
            scl_q   <= 1'b1;
            state_q <= ufi_pkg::UFI_STP2;
          end
          default: begin
            oe_n_q  <= 1'b1;
            drv_q   <= 1'b1;
            busy_q  <= 1'b0;
            if (cmd_q[15]) begin
              rdbuf_q <= rx_q;
            end
            state_q <= ufi_pkg::UFI_IDLE;
          end
        endcase
      end
    end
  end

  assign link.scl          = scl_q;
  assign link.sda_mcu_drv  = drv_q;
  assign link.sda_mcu_oe_n = oe_n_q;
endmodule

// *** tb/ufi_asserts.sv ***
// Wire checks on the two-wire link and the interrupt pin
`timescale 1ns/10ps
module ufi_asserts (
  input wire logic aclk,         // clock
  input wire logic aresetn,      // reset, low
  input wire logic scl,          // link clock
  input wire logic sda_dev_oe_n, // device drive, low
  input wire logic sda,          // data line
  input wire logic irq           // interrupt pin
);
  logic       scl_p_q;
  logic       sda_p_q;
  logic       frm_q;
  logic       rd_q;
  logic [4:0] rise_q;
  wire        start_w = scl && scl_p_q && sda_p_q && !sda;
  wire        stop_w  = scl && scl_p_q && !sda_p_q && sda;
  wire        rise_w  = scl && !scl_p_q && frm_q;
  wire        frame_w = frm_q || start_w;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      frm_q   <= 1'b0;
      rd_q    <= 1'b0;
      rise_q  <= 5'h00;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      frm_q   <= start_w || (frm_q && !stop_w);
      rise_q  <= start_w ? 5'h00 : rise_q + 5'(rise_w);
      // First bit of a frame says read
      if (rise_w && rise_q == 5'h00) begin
        rd_q <= sda;
      end
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_held_high;
    scl [*8];
  endsequence
  sequence s_held_low;
    !scl [*8];
  endsequence
  a_scl_high_time: assert property ($rose(scl) |-> s_held_high)
    else $error("link clock high phase too short");
  a_scl_low_time: assert property ($fell(scl) |-> s_held_low)
    else $error("link clock low phase too short");
  a_data_stable_high: assert property ($rose(scl) && frame_w |=> $stable(sda) [*7])
    else $error("data line moved while link clock high");
  a_frame_bit_count: assert property (stop_w && frm_q |-> rise_q == 5'h11)
    else $error("frame length is not sixteen bits");
  a_dev_drive_slot: assert property (!sda_dev_oe_n |-> frm_q && rd_q && rise_q >= 5'h08)
    else $error("device drove data outside read data bits");
  a_idle_lines_high: assert property (!frame_w |-> scl && sda && sda_dev_oe_n)
    else $error("link not idle between frames");
  a_stop_dev_free: assert property (stop_w |-> sda_dev_oe_n)
    else $error("device still driving at stop");
  a_reset_quiet: assert property ($rose(aresetn) |-> scl && sda && !irq)
    else $error("pins not quiet after reset");
endmodule

// *** tb/tb.sv ***
// Bench: AXI4-Lite orders through the controller end reach the function end
`timescale 1ns/10ps
`include "ufi_cfg.svh"
module tb;
  logic        aclk = 1'b0;
  logic        aresetn, susp, prst, sa_stb, pe_stb;
  logic [8:0]  cause;
  logic [6:0]  sa_val;
  logic        low_power_q, function_reset_q;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r;
  int          fail_count, checked, function_reset_flag_cnt;
  ufi_link_if link_if ();
  ufi_dev ufi_dev_inst (.aclk(aclk), .aresetn(aresetn), .link(link_if),
    .suspend_detect(susp), .port_reset_detect(prst), .ep1_tx_cause(cause[8:6]),
    .ep0_rx_cause(cause[5:3]), .ep0_tx_cause(cause[2:0]), .set_address_stb(sa_stb),
    .set_address_val(sa_val), .port_enable_stb(pe_stb), .low_power_q(low_power_q),
    .function_reset_q(function_reset_q));
  ufi_mcu ufi_mcu_inst (.aclk(aclk), .aresetn(aresetn), .link(link_if),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ufi_asserts ufi_asserts_inst (.aclk(aclk), .aresetn(aresetn), .scl(link_if.scl),
    .sda_dev_oe_n(link_if.sda_dev_oe_n), .sda(link_if.sda), .irq(link_if.irq));
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    if (!aresetn) function_reset_flag_cnt <= 0;
    else if (function_reset_q === 1'b1) function_reset_flag_cnt <= function_reset_flag_cnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 1000);
    r = bresp;
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      chk(bvalid, 32'h1);
      test_done();
    end
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 1000);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      chk(rvalid, 32'h1);
      test_done();
    end
  endtask
  // Poll busy until the frame has finished
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      axi_rd(`UFI_AXI_STAT);
      n++;
    end while (d[0] !== 1'b0 && n < 500);
    if (d[0] !== 1'b0) begin
      chk(d[0], 32'h0);
      test_done();
    end
  endtask
  task automatic dev_wr(input logic [6:0] a, input logic [7:0] b);
    axi_wr(`UFI_AXI_CMD, {16'h0000, 1'b0, a, b});
    chk(r, `UFI_RESP_OKAY);
    wait_idle();
  endtask
  task automatic reg_chk(input logic [6:0] a, input logic [7:0] e);
    axi_wr(`UFI_AXI_CMD, {16'h0000, 1'b1, a, 8'h00});
    wait_idle();
    axi_rd(`UFI_AXI_RDATA);
    chk(r, `UFI_RESP_OKAY);
    chk(d[7:0], e);
  endtask
  task automatic test_done();
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    {susp, prst, sa_stb, pe_stb, awvalid, wvalid, bready, arvalid, rready} = 9'h000;
    {cause, sa_val, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    fail_count = 0;
    checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) reg_chk(7'(i), 8'h00);
    chk(link_if.irq, 32'h0);
    // One cause of each endpoint flag, masked
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      cause <= 9'h001 << (4 * i);
      dev_wr(`UFI_REG_PEND, 8'h07);
      reg_chk(`UFI_REG_PEND, 8'(1 << i));
      chk(link_if.irq, 32'h0);
      @(posedge aclk);
      cause <= 9'h000;
      reg_chk(`UFI_REG_PEND, 8'h00);
    end
    dev_wr(`UFI_REG_MASK, 8'h1F);
    reg_chk(`UFI_REG_MASK, 8'h1F);
    @(posedge aclk);
    cause <= 9'h040;
    repeat (8) @(posedge aclk);
    chk(link_if.irq, 32'h1);
    axi_rd(`UFI_AXI_STAT);
    chk(d[1], 32'h1);
    @(posedge aclk);
    cause <= 9'h000;
    repeat (4) @(posedge aclk);
    chk(link_if.irq, 32'h0);
    @(posedge aclk);
    susp <= 1'b1;
    reg_chk(`UFI_REG_PEND, 8'h10);
    chk(link_if.irq, 32'h1);
    chk(low_power_q, 32'h0);
    dev_wr(`UFI_REG_PEND, 8'h00);
    reg_chk(`UFI_REG_PEND, 8'h10);
    dev_wr(`UFI_REG_PEND, 8'h10);
    chk(low_power_q, 32'h1);
    chk(link_if.irq, 32'h0);
    @(posedge aclk);
    susp <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(low_power_q, 32'h0);
    @(posedge aclk);
    prst <= 1'b1;
    sa_stb <= 1'b1;
    sa_val <= 7'h2A;
    pe_stb <= 1'b1;
    @(posedge aclk);
    {sa_stb, pe_stb} <= 2'b00;
    reg_chk(`UFI_REG_FADDR, 8'hAA);
    reg_chk(`UFI_REG_PEND, 8'h08);
    chk(function_reset_flag_cnt, 32'h0);
    dev_wr(`UFI_REG_PEND, 8'h08);
    prst <= 1'b0;
    chk(function_reset_flag_cnt, 32'h1);
    reg_chk(`UFI_REG_FADDR, 8'h80);
    reg_chk(`UFI_REG_MASK, 8'h1F);
    dev_wr(`UFI_REG_FADDR, 8'h55);
    reg_chk(`UFI_REG_FADDR, 8'hD5);
    reg_chk(7'h05, 8'h00);
    // Command without both low strobes is refused: no frame, old command kept
    wstrb <= 4'h0;
    axi_wr(`UFI_AXI_CMD, 32'h00000255);
    chk(r, `UFI_RESP_OKAY);
    axi_rd(`UFI_AXI_CMD);
    chk(d, 32'h00008500);
    axi_rd(`UFI_AXI_STAT);
    chk(d, 32'h0);
    wstrb <= 4'hF;
    axi_rd(4'hC);
    chk(r, `UFI_RESP_SLVERR);
    chk(d, 32'h0);
    axi_wr(4'hC, 32'h0);
    chk(r, `UFI_RESP_SLVERR);
    test_done();
  end
  initial begin
    #600000;
    fail_count++;
    test_done();
  end
endmodule
